// *** common/fts_defs.svh ***
// Constants for the flow-through SRAM port control block.
// Assumes inclusion by bare name from files under hw/ and verification/.
`ifndef FTS_DEFS_SVH
`define FTS_DEFS_SVH
// =============================================================
// Widths and depth
`define FTS_ADDR_W 18
`define FTS_DATA_W 16
`define FTS_PAR_W 2
`define FTS_WORD_W 18
`define FTS_DEPTH 262144
`define FTS_BEAT_W 2
// =============================================================
// Field positions and strap values
`define FTS_LOW_HI 1
`define FTS_HIGH_LO 2
`define FTS_BYTE0_LO 0
`define FTS_BYTE1_LO 9
`define FTS_ORDER_LINEAR 1'b0
`define FTS_ORDER_INTERLEAVED 1'b1
// =============================================================
// Timing counts
`define FTS_STRAP_SETTLE 2'h2
`endif

// *** common/fts_pkg.sv ***
// Types shared by the flow-through SRAM port control block.
// Assumes the constants header is on the include path.
package fts_pkg;
  // =============================================================
  // Operation held between clock edges
  typedef enum logic [1:0] {
    op_idle = 2'b00,
    op_read = 2'b01,
    op_write = 2'b10
  } fts_op_t;
endpackage : fts_pkg

// *** common/fts_burst_if.sv ***
// Carrier between the port control and its burst counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface fts_burst_if;
  logic load;
  logic step;
  logic order;
  logic [1:0] base_low;
  logic [1:0] step_low;
  modport ctrl (output load, output step, output order, output base_low, input step_low);
  modport ctr (input load, input step, input order, input base_low, output step_low);
endinterface : fts_burst_if

// *** hw/fts_burst_ctr.sv ***
// Four-beat burst counter for the SRAM port control.
// Assumes load and step are already qualified by the clock qualify input.
`timescale 1ns/100ps
`include "fts_defs.svh"
module fts_burst_ctr
  import fts_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  fts_burst_if.ctr bus
);
  // =============================================================
  // Beat sequencing
  logic [1:0] beat_reg;
  logic [1:0] beat_next;
  logic [1:0] beat_inc;

  function automatic logic [1:0] fts_mix(input logic order, input logic [1:0] base, input logic [1:0] beat);
    fts_mix = (order == `FTS_ORDER_LINEAR) ? 2'(base + beat) : (base ^ beat);
  endfunction : fts_mix

  always_comb begin
    beat_inc = 2'(beat_reg + 2'h1);
    beat_next = beat_reg;
    if (bus.load) begin
      beat_next = 2'h0;
    end else if (bus.step) begin
      beat_next = beat_inc; // [R14]
    end
    bus.step_low = fts_mix(bus.order, bus.base_low, beat_inc); // [R14]
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      beat_reg <= 2'h0;
    end else begin
      beat_reg <= beat_next;
    end
  end

  // =============================================================
  // Checks
  beat_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R14]
    bus.step && !bus.load |=> beat_reg == 2'($past(beat_reg) + 2'h1))
    else $error("Burst beat did not step by one.");
  beat_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R14]
    bus.load |=> beat_reg == 2'h0)
    else $error("Burst beat not cleared on load.");
endmodule : fts_burst_ctr

// *** hw/fts_port_ctrl.sv ***
// Flow-through burst SRAM port: selection, suspension, drive control and core.
// Assumes the controller shares clk_sys; only the output enable and strap are asynchronous.
`timescale 1ns/100ps
`include "fts_defs.svh"
// Summary of operation
// R1 - Selected only when A low, B high, C low
// R2 - Low output enable lets data pins drive
// R3 - Float during write data, deselect, emerging
// R4 - High clock qualify freezes all state; the output enable synchroniser, drive enable and strap capture keep running
// R5 - Clock qualify never deselects; stretches operation
// R6 - Capture all sixteen data bits on edge
// R7 - Read data from previous edge's address
// R8 - Parity lines follow data; gated per byte
// R9 - Strap high interleaved, low linear, constant
// R10 - Byte selects low-active, gate low/high bytes
// R11 - Controller drives write enable low to write
// R12 - Advance high steps burst, low loads address
// R13 - Eighteen-bit address selects one location
// R14 - Burst steps lowest two address bits
module fts_port_ctrl
  import fts_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic clock_qualify_n,
  input wire logic write_enable_n,
  input wire logic advance_or_load,
  input wire logic [1:0] byte_write_select_n,
  input wire logic [`FTS_ADDR_W-1:0] address,
  input wire logic burst_order_strap,
  input wire logic output_enable_n,
  input wire logic [`FTS_DATA_W-1:0] data_in,
  input wire logic [`FTS_PAR_W-1:0] parity_lines_in,
  output logic [`FTS_DATA_W-1:0] data_out,
  output logic data_oe,
  output logic [`FTS_PAR_W-1:0] parity_lines_out,
  output logic parity_oe
);
  // =============================================================
  // Helpers
  function automatic logic fts_selected(input logic a_n, input logic b, input logic c_n);
    fts_selected = !a_n && b && !c_n;
  endfunction : fts_selected

  function automatic logic [`FTS_WORD_W-1:0] fts_merge(input logic [`FTS_WORD_W-1:0] old_w,
      input logic [`FTS_WORD_W-1:0] new_w, input logic [1:0] bws_n);
    fts_merge = old_w;
    if (!bws_n[0]) fts_merge[`FTS_BYTE1_LO-1:`FTS_BYTE0_LO] = new_w[`FTS_BYTE1_LO-1:`FTS_BYTE0_LO];
    if (!bws_n[1]) fts_merge[`FTS_WORD_W-1:`FTS_BYTE1_LO] = new_w[`FTS_WORD_W-1:`FTS_BYTE1_LO];
  endfunction : fts_merge

  // =============================================================
  // State
  fts_op_t op_reg, op_next;
  logic [`FTS_ADDR_W-1:0] base_reg, base_next;
  logic pend_wr_reg, pend_wr_next;
  logic [`FTS_ADDR_W-1:0] pend_addr_reg, pend_addr_next;
  logic [1:0] pend_bws_reg, pend_bws_next;
  logic rd_phase_reg, rd_phase_next;
  logic [`FTS_DATA_W-1:0] data_out_reg, data_out_next;
  logic [`FTS_PAR_W-1:0] par_out_reg, par_out_next;
  logic data_oe_reg, data_oe_next;
  logic oe_s1_reg, oe_s2_reg;
  logic strap_s1_reg, strap_s2_reg;
  logic order_reg, order_next;
  logic strap_done_reg, strap_done_next;
  logic [1:0] strap_wait_reg, strap_wait_next;
  logic [`FTS_WORD_W-1:0] mem_array [0:`FTS_DEPTH-1];

  logic run, sel, load, step, go_rd, go_wr, mem_we;
  logic [`FTS_ADDR_W-1:0] acc_addr;
  logic [`FTS_WORD_W-1:0] wr_word, rd_word;

  fts_burst_if burst ();

  fts_burst_ctr u_burst (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .bus(burst.ctr)
  );

  // =============================================================
  // Command decode
  always_comb begin
    run = !clock_qualify_n; // [R4]
    sel = fts_selected(chip_select_a_n, chip_select_b, chip_select_c_n); // [R1]
    load = run && !advance_or_load; // [R12]
    step = run && advance_or_load && (op_reg != op_idle); // [R12] [R14]
    burst.load = load;
    burst.step = step;
    burst.order = order_reg;
    burst.base_low = base_reg[`FTS_LOW_HI:0];
    acc_addr = load ? address : {base_reg[`FTS_ADDR_W-1:`FTS_HIGH_LO], burst.step_low}; // [R13]
    go_rd = (load && sel && write_enable_n) || (step && op_reg == op_read);
    go_wr = (load && sel && !write_enable_n) || (step && op_reg == op_write);
    mem_we = run && pend_wr_reg; // [R6]
    wr_word = {parity_lines_in[1], data_in[`FTS_DATA_W-1:8], parity_lines_in[0], data_in[7:0]}; // [R8]
    rd_word = mem_array[acc_addr];
    // A write landing on the address being read must be seen by that read.
    if (mem_we && pend_addr_reg == acc_addr) begin
      rd_word = fts_merge(rd_word, wr_word, pend_bws_reg);
    end
  end

  // =============================================================
  // Next state
  always_comb begin
    op_next = op_reg;
    base_next = base_reg;
    pend_wr_next = pend_wr_reg;
    pend_addr_next = pend_addr_reg;
    pend_bws_next = pend_bws_reg;
    rd_phase_next = rd_phase_reg;
    data_out_next = data_out_reg;
    par_out_next = par_out_reg;
    if (run) begin // [R4] [R5]
      if (load) begin
        op_next = !sel ? op_idle : (write_enable_n ? op_read : op_write); // [R1]
        if (sel) begin
          base_next = address;
        end
      end
      pend_wr_next = go_wr;
      pend_addr_next = acc_addr;
      pend_bws_next = byte_write_select_n; // [R10]
      rd_phase_next = go_rd; // [R3]
      if (go_rd) begin
        data_out_next = {rd_word[`FTS_WORD_W-2:`FTS_BYTE1_LO], rd_word[`FTS_BYTE1_LO-2:0]}; // [R7]
        par_out_next = {rd_word[`FTS_WORD_W-1], rd_word[`FTS_BYTE1_LO-1]}; // [R8]
      end
    end
    data_oe_next = rd_phase_next && !oe_s2_reg; // [R2] [R3]
    // The strap is taken only once the synchroniser holds the pin's level, not its reset value.
    strap_wait_next = (strap_wait_reg == `FTS_STRAP_SETTLE) ? strap_wait_reg : 2'(strap_wait_reg + 2'h1);
    strap_done_next = strap_done_reg || (strap_wait_reg == `FTS_STRAP_SETTLE);
    order_next = strap_done_reg ? order_reg : strap_s2_reg; // [R9]
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg <= op_idle;
      base_reg <= '0;
      pend_wr_reg <= 1'b0;
      pend_addr_reg <= '0;
      pend_bws_reg <= 2'h3;
      rd_phase_reg <= 1'b0;
      data_out_reg <= '0;
      par_out_reg <= '0;
      data_oe_reg <= 1'b0;
      oe_s1_reg <= 1'b1;
      oe_s2_reg <= 1'b1;
      strap_s1_reg <= `FTS_ORDER_INTERLEAVED;
      strap_s2_reg <= `FTS_ORDER_INTERLEAVED;
      order_reg <= `FTS_ORDER_INTERLEAVED;
      strap_done_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
    end else begin
      op_reg <= op_next;
      base_reg <= base_next;
      pend_wr_reg <= pend_wr_next;
      pend_addr_reg <= pend_addr_next;
      pend_bws_reg <= pend_bws_next;
      rd_phase_reg <= rd_phase_next;
      data_out_reg <= data_out_next;
      par_out_reg <= par_out_next;
      data_oe_reg <= data_oe_next;
      oe_s1_reg <= output_enable_n;
      oe_s2_reg <= oe_s1_reg;
      strap_s1_reg <= burst_order_strap;
      strap_s2_reg <= strap_s1_reg;
      order_reg <= order_next;
      strap_done_reg <= strap_done_next;
      strap_wait_reg <= strap_wait_next;
    end
  end

  // The core array carries no reset; its contents are undefined until written.
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem_array[pend_addr_reg] <= fts_merge(mem_array[pend_addr_reg], wr_word, pend_bws_reg); // [R6] [R8] [R10]
    end
  end

  assign data_out = data_out_reg;
  assign data_oe = data_oe_reg;
  assign parity_lines_out = par_out_reg;
  assign parity_oe = data_oe_reg; // [R8]

  // =============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence wr_cmd_s;
    load && sel && !write_enable_n;
  endsequence
  sequence wr_data_s;
    pend_wr_reg && !data_oe;
  endsequence

  desel_float_a: assert property (load && !sel |=> !data_oe && op_reg == op_idle) // [R1] [R3]
    else $error("Drive seen after deselect.");
  oe_gate_a: assert property (data_oe |-> !$past(oe_s2_reg) && rd_phase_reg) // [R2]
    else $error("Data driven without output enable.");
  write_float_a: assert property (wr_cmd_s |=> wr_data_s) // [R3]
    else $error("Data driven in write data phase.");
  hold_a: assert property (clock_qualify_n |=> $stable(base_reg) && $stable(data_out) && $stable(op_reg)) // [R4]
    else $error("State moved while suspended.");
  no_desel_a: assert property (clock_qualify_n && op_reg != op_idle |=> op_reg == $past(op_reg)) // [R5]
    else $error("Suspension changed the operation.");
  capture_a: assert property (pend_wr_reg && run && pend_bws_reg == 2'h0 |=> mem_array[$past(pend_addr_reg)] == $past(wr_word)) // [R6]
    else $error("Write data not captured.");
  flow_a: assert property (run && go_rd |=> data_out[7:0] == $past(rd_word[7:0])) // [R7]
    else $error("Read data not from the sampled address.");
  flow_hi_a: assert property (run && go_rd |=> data_out[15:8] == $past(rd_word[16:9])) // [R7]
    else $error("Read high byte mismatch.");
  parity_a: assert property (run && go_rd |=> parity_lines_out == {$past(rd_word[17]), $past(rd_word[8])}) // [R8]
    else $error("Read parity not from the sampled address.");
  order_a: assert property (strap_done_reg |=> $stable(order_reg)) // [R9]
    else $error("Burst order changed after capture.");
  byte_a: assert property (wr_cmd_s |=> pend_bws_reg == $past(byte_write_select_n)) // [R10]
    else $error("Byte selects not held for the data phase.");
  adv_a: assert property (step |=> base_reg == $past(base_reg) && op_reg == $past(op_reg)) // [R12]
    else $error("Advance disturbed the burst base.");
  addr_a: assert property (load && sel |=> base_reg == $past(address)) // [R13]
    else $error("Address not loaded.");
endmodule : fts_port_ctrl

// *** verification/fts_ctrl_model.sv ***
// Behavioural memory controller side: resolves the shared data and parity lines.
// Assumes the bench raises host_drive only while the port has floated its lines.
`timescale 1ns/100ps
`include "fts_defs.svh"
module fts_ctrl_model (
  input wire logic clk_sys,
  input wire logic data_oe,
  input wire logic [`FTS_DATA_W-1:0] data_out,
  input wire logic parity_oe,
  input wire logic [`FTS_PAR_W-1:0] parity_lines_out,
  input wire logic host_drive,
  input wire logic [`FTS_WORD_W-1:0] host_word,
  output logic [`FTS_DATA_W-1:0] data_in,
  output logic [`FTS_PAR_W-1:0] parity_lines_in
);
  // =============================================================
  // Line resolution
  // An undriven line shows the inverse of its last level, so a stale value never passes a check.
  logic [`FTS_WORD_W-1:0] last_reg = 18'h00000;
  always_comb begin
    data_in = data_oe ? data_out : (host_drive ? host_word[15:0] : ~last_reg[15:0]);
    parity_lines_in = parity_oe ? parity_lines_out : (host_drive ? host_word[17:16] : ~last_reg[17:16]);
  end
  always @(posedge clk_sys) begin
    last_reg <= {parity_lines_in, data_in};
  end
endmodule : fts_ctrl_model

// *** verification/fts_port_ctrl_test.sv ***
// Self-checking bench for the flow-through SRAM port control.
// Assumes the controller model resolves the shared lines; the strap is set only under reset.
`timescale 1ns/100ps
`include "fts_defs.svh"
module fts_port_ctrl_test;
  import fts_pkg::*;
  // =============================================================
  // Stimulus and wiring
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] sel = 3'b110;
  logic cq_n = 1'b1, we_n = 1'b1, adv = 1'b0, strap = 1'b1, oe_n = 1'b0, drv = 1'b0;
  logic [1:0] bws_n = 2'b11;
  logic [17:0] addr = 18'h00000, hw = 18'h00000;
  logic [15:0] d_in, d_out;
  logic [1:0] p_in, p_out;
  logic d_oe, p_oe;
  logic [17:0] mdl [0:7];
  int fails = 0, checks = 0, cycles = 0;
  fts_port_ctrl uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .chip_select_a_n(sel[2]), .chip_select_b(sel[1]),
    .chip_select_c_n(sel[0]), .clock_qualify_n(cq_n), .write_enable_n(we_n), .advance_or_load(adv),
    .byte_write_select_n(bws_n), .address(addr), .burst_order_strap(strap), .output_enable_n(oe_n),
    .data_in(d_in), .parity_lines_in(p_in), .data_out(d_out), .data_oe(d_oe),
    .parity_lines_out(p_out), .parity_oe(p_oe));
  fts_ctrl_model model (.clk_sys(clk_sys), .data_oe(d_oe), .data_out(d_out), .parity_oe(p_oe),
    .parity_lines_out(p_out), .host_drive(drv), .host_word(hw), .data_in(d_in), .parity_lines_in(p_in));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // =============================================================
  // Shared tasks
  task finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      finish_test;
    end
  end
  task chk(input logic [17:0] seen, input logic [17:0] exp, input string what);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // One command taken at one qualified edge; the bus is then frozen by a high qualify.
  task cmd(input logic [2:0] s, input logic w, input logic a, input logic [1:0] b, input logic [17:0] ad,
           input logic dv, input logic [17:0] wd);
    @(posedge clk_sys);
    sel <= s;
    cq_n <= 1'b0;
    we_n <= w;
    adv <= a;
    bws_n <= b;
    addr <= ad;
    drv <= dv;
    hw <= wd;
    @(posedge clk_sys);
    cq_n <= 1'b1;
    drv <= 1'b0;
    #1;
  endtask : cmd
  task rd(input logic [17:0] ad);
    cmd(3'b010, 1'b1, 1'b0, 2'b00, ad, 1'b0, 18'h00000);
  endtask : rd
  // Expected memory image for the low eight words, merged by byte selects.
  task put(input logic [17:0] ad, input logic [1:0] b, input logic [17:0] wd);
    if (ad < 8) begin
      if (!b[0]) mdl[ad[2:0]] = {mdl[ad[2:0]][17], wd[16], mdl[ad[2:0]][15:8], wd[7:0]};
      if (!b[1]) mdl[ad[2:0]] = {wd[17], mdl[ad[2:0]][16], wd[15:8], mdl[ad[2:0]][7:0]};
    end
  endtask : put
  // Write load, then data phase carried by a deselect with the controller driving the lines.
  task wr(input logic [17:0] ad, input logic [1:0] b, input logic [17:0] wd);
    cmd(3'b010, 1'b0, 1'b0, b, ad, 1'b0, 18'h00000);
    chk({17'h00000, d_oe}, 18'h00000, "oe on write load");
    cmd(3'b110, 1'b1, 1'b0, 2'b11, 18'h00000, 1'b1, wd);
    chk({16'h0000, p_oe, d_oe}, 18'h00000, "oe on deselect");
    put(ad, b, wd);
  endtask : wr
  task do_reset(input logic s);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    strap <= s;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset
  // =============================================================
  // Scenarios
  task t_write_read;
    for (int i = 0; i < 8; i++) wr(18'(i), 2'b00, 18'h2A5A0 ^ (18'(i) * 18'h01111));
    wr(18'h3FFFF, 2'b00, 18'h1C3E7);
    for (int i = 0; i < 8; i++) begin
      rd(18'(i));
      chk({p_out, d_out}, mdl[i], "read back");
    end
    rd(18'h3FFFF);
    chk({p_out, d_out}, 18'h1C3E7, "top address");
    rd(18'h00007);
    chk({p_out, d_out}, 18'h2A5A0 ^ 18'h07777, "top did not alias");
    $display("test write_read done");
  endtask : t_write_read
  task t_bytes;
    wr(18'h00005, 2'b10, 18'h3FFFF);
    wr(18'h00006, 2'b01, 18'h00000);
    wr(18'h00007, 2'b11, 18'h12345);
    // A read loaded at the capture edge of a write to the same word must see the new bytes.
    cmd(3'b010, 1'b0, 1'b0, 2'b01, 18'h00006, 1'b0, 18'h00000);
    cmd(3'b010, 1'b1, 1'b0, 2'b00, 18'h00006, 1'b1, 18'h3A55A);
    put(18'h00006, 2'b01, 18'h3A55A);
    chk({p_out, d_out}, mdl[6], "read meets write");
    for (int i = 5; i < 8; i++) begin
      rd(18'(i));
      chk({p_out, d_out}, mdl[i], "byte gating");
    end
    $display("test bytes done");
  endtask : t_bytes
  task t_select;
    for (int s = 0; s < 8; s++) begin
      cmd(3'(s), 1'b1, 1'b0, 2'b00, 18'h00004, 1'b0, 18'h00000);
      chk({17'h00000, d_oe}, {17'h00000, s == 2}, "select decode");
      chk({17'h00000, p_oe}, {17'h00000, s == 2}, "parity drive");
    end
    $display("test select done");
  endtask : t_select
  task t_oe;
    @(posedge clk_sys);
    oe_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(18'h00004);
    chk({17'h00000, d_oe}, 18'h00000, "oe high floats");
    @(posedge clk_sys);
    oe_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(18'h00004);
    chk({17'h00000, d_oe}, 18'h00001, "oe low drives");
    $display("test oe done");
  endtask : t_oe
  // Freeze for six edges with junk on the bus, then advance through the burst from base 5.
  task t_burst(input logic s);
    logic [1:0] low;
    rd(18'h00005);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      sel <= 3'(k);
      adv <= k[0];
      we_n <= k[1];
      addr <= 18'(k);
    end
    #1;
    chk({p_out, d_out}, mdl[5], "frozen data");
    chk({17'h00000, d_oe}, 18'h00001, "frozen drive");
    for (int k = 1; k < 4; k++) begin
      cmd(3'b000, 1'b0, 1'b1, 2'b00, 18'h00000, 1'b0, 18'h00000);
      low = s ? (2'b01 ^ 2'(k)) : (2'b01 + 2'(k));
      chk({p_out, d_out}, mdl[{1'b1, low}], "burst beat");
    end
    $display("test burst done");
  endtask : t_burst
  // =============================================================
  // Main sequence
  initial begin
    do_reset(1'b1);
    t_write_read;
    t_bytes;
    t_select;
    t_oe;
    t_burst(1'b1);
    do_reset(1'b0);
    t_burst(1'b0);
    finish_test;
  end
endmodule : fts_port_ctrl_test
